// *** hw/lat_regs.sv ***
// Lane FIFO alarm and offset trim register bank behind an AHB-Lite slave
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1: lane FIFO fault sets its lane bit
// R2: writing one clears lane bit
// R3: persisting fault sets bit again next cycle
// R4: summary clear-write clears all lane bits
// R5: core 0 trim 12 bits, applied
// R6: core 1 trim 12 bits, applied
// R7: input-A trim applied while sampling pair A
// R8: input-B trim applied while sampling pair B
// R9: software avoids trims during offset calibration
// R10: wait for foreground done before trim access
// R11: no trim access with both background enables
// R12: recommended background setup without background offset
// R13: spare cores calibrated in foreground step
// R14: offset calibration off: access anytime
// R15: software writes zero to bits 15:12
// R16: trims loaded from fuses at start-up
// R17: summary alarm sets on any lane fault; the code sets it only for faulting lanes that also have lane_active set
// R18: all alarm bits one after reset
// R19: fault beats simultaneous clear
module lat_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [lat_pkg::LAT_LANES-1:0] lane_fifo_fault,
    input wire logic [lat_pkg::LAT_LANES-1:0] lane_active,
    input wire logic foreground_cal_done,
    input wire logic cal_busy,
    input wire logic core2_sel_input_b,
    input wire logic [lat_pkg::LAT_TRIM_W-1:0] fuse_core0_trim,
    input wire logic [lat_pkg::LAT_TRIM_W-1:0] fuse_core1_trim,
    input wire logic [lat_pkg::LAT_TRIM_W-1:0] fuse_core2a_trim,
    input wire logic [lat_pkg::LAT_TRIM_W-1:0] fuse_core2b_trim,
    output logic [lat_pkg::LAT_TRIM_W-1:0] core0_trim,
    output logic [lat_pkg::LAT_TRIM_W-1:0] core1_trim,
    output logic [lat_pkg::LAT_TRIM_W-1:0] core2_trim,
    output logic offset_cal_enable,
    output logic background_cal_enable,
    output logic background_offset_cal_enable,
    output logic irq
);
    import lat_pkg::*;

    localparam int NTRIM = 4;

    // Synchronised pin inputs
    logic [LAT_LANES-1:0] fault_s1_q;
    logic [LAT_LANES-1:0] fault_s2_q;
    logic [LAT_LANES-1:0] act_s1_q;
    logic [LAT_LANES-1:0] act_s2_q;
    logic done_s1_q;
    logic done_s2_q;
    logic busy_s1_q;
    logic busy_s2_q;
    logic selb_s1_q;
    logic selb_s2_q;

    // Bus address phase capture, fuse load flag and register state
    logic wr_pend_q;
    logic rd_pend_q;
    logic [9:0] idx_q;
    logic fuse_load_q;
    logic [2:0] cal_ctrl_q;
    logic [7:0] mask_q;
    logic [31:0] rdata_q;

    // Two-flop synchronisers for lane, calibration and core 2 input pair select inputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_s1_q <= '0;
            fault_s2_q <= '0;
            act_s1_q <= '0;
            act_s2_q <= '0;
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            busy_s1_q <= 1'b0;
            busy_s2_q <= 1'b0;
            selb_s1_q <= 1'b0;
            selb_s2_q <= 1'b0;
        end else begin
            fault_s1_q <= lane_fifo_fault;
            fault_s2_q <= fault_s1_q;
            act_s1_q <= lane_active;
            act_s2_q <= act_s1_q;
            done_s1_q <= foreground_cal_done;
            done_s2_q <= done_s1_q;
            busy_s1_q <= cal_busy;
            busy_s2_q <= busy_s1_q;
            selb_s1_q <= core2_sel_input_b;
            selb_s2_q <= selb_s1_q;
        end
    end

    // Address phase decode
    wire addr_ok = hsel & hready & (htrans == LAT_HTRANS_NONSEQ);
    wire [9:0] idx_d = haddr[11:2];
    wire wr_go = wr_pend_q;
    wire [15:0] wd16 = hwdata[15:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q <= '0;
        end else begin
            wr_pend_q <= addr_ok & hwrite;
            rd_pend_q <= addr_ok & ~hwrite;
            idx_q <= idx_d;
        end
    end

    // Register selects in the data phase (byte address = 4 x index)
    wire sel_lane = (idx_q == LAT_IDX_LANE_FLAGS[9:0]);
    wire sel_sum = (idx_q == LAT_IDX_SUMMARY[9:0]);
    wire sel_mask = (idx_q == LAT_IDX_IRQ_MASK[9:0]);
    wire sel_cal = (idx_q == LAT_IDX_CAL_CTRL[9:0]);
    wire [NTRIM-1:0] sel_trim;
    assign sel_trim[0] = (idx_q == LAT_IDX_CORE0_TRIM[9:0]);
    assign sel_trim[1] = (idx_q == LAT_IDX_CORE1_TRIM[9:0]);
    assign sel_trim[2] = (idx_q == LAT_IDX_CORE2A_TRIM[9:0]);
    assign sel_trim[3] = (idx_q == LAT_IDX_CORE2B_TRIM[9:0]);

    // Lane flags: fault sets, one-write clears, summary clear-write clears all
    wire sum_clr = wr_go & sel_sum & wd16[LAT_SUMMARY_BIT]; // [R4]
    wire [LAT_LANES-1:0] lane_flags;
    wire summary_flag;
    genvar gi;
    generate
        for (gi = 0; gi < LAT_LANES; gi++) begin : g_lane
            lat_sticky_bit u_bit (
                .hclk(hclk),
                .hresetn(hresetn),
                .set_i(fault_s2_q[gi]), // [R1] [R3]
                .clr_i((wr_go & sel_lane & wd16[gi]) | sum_clr), // [R2] [R4]
                .flag_o(lane_flags[gi])
            );
        end
    endgenerate

    // Summary alarm: any active lane fault
    lat_sticky_bit u_summary (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_i(|(fault_s2_q & act_s2_q)), // [R17]
        .clr_i(sum_clr), // [R17]
        .flag_o(summary_flag)
    );

    // Trim registers with fuse preload one cycle after reset release
    wire [LAT_TRIM_W-1:0] fuse_val [NTRIM];
    wire [LAT_TRIM_W-1:0] trim_val [NTRIM];
    assign fuse_val[0] = fuse_core0_trim;
    assign fuse_val[1] = fuse_core1_trim;
    assign fuse_val[2] = fuse_core2a_trim;
    assign fuse_val[3] = fuse_core2b_trim;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuse_load_q <= 1'b1;
        end else begin
            fuse_load_q <= 1'b0;
        end
    end

    generate
        for (gi = 0; gi < NTRIM; gi++) begin : g_trim
            lat_trim_reg #(.WIDTH(LAT_TRIM_W)) u_trim (
                .hclk(hclk),
                .hresetn(hresetn),
                .fuse_load_i(fuse_load_q), // [R16]
                .fuse_value_i(fuse_val[gi]),
                .wr_i(wr_go & sel_trim[gi]), // [R15]
                .wdata_i(wd16[LAT_TRIM_W-1:0]),
                .trim_o(trim_val[gi])
            );
        end
    endgenerate

    // Trim application; core 2 picks by input pair
    assign core0_trim = trim_val[0]; // [R5]
    assign core1_trim = trim_val[1]; // [R6]
    assign core2_trim = selb_s2_q ? trim_val[3] : trim_val[2]; // [R7] [R8]

    // Calibration enables and interrupt mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_ctrl_q <= LAT_CAL_CTRL_RST;
            mask_q <= LAT_IRQ_MASK_RST;
        end else begin
            if (wr_go & sel_cal) begin
                cal_ctrl_q <= wd16[2:0];
            end
            if (wr_go & sel_mask) begin
                mask_q <= wd16[7:0];
            end
        end
    end

    // Foreground step covers spare cores even with background offset off
    assign offset_cal_enable = cal_ctrl_q[LAT_OFFSET_CAL_ENABLE_BIT]; // [R13]
    assign background_cal_enable = cal_ctrl_q[LAT_BACKGROUND_CAL_ENABLE_BIT];
    assign background_offset_cal_enable = cal_ctrl_q[LAT_BACKGROUND_OFFSET_CAL_ENABLE_BIT]; // [R12]

    // Interrupt: summary bit set and not masked
    assign irq = summary_flag & ~mask_q[LAT_SUMMARY_BIT];

    // Read mux, status visible for the software access checks
    wire [15:0] sum_word = 16'(summary_flag) << LAT_SUMMARY_BIT;
    wire [15:0] cal_word = {11'h000, busy_s2_q, done_s2_q, cal_ctrl_q}; // [R10] [R9]
    wire [15:0] rd_mux =
        sel_lane ? {8'h00, lane_flags} :
        sel_sum ? sum_word :
        sel_mask ? {8'h00, mask_q} :
        sel_cal ? cal_word :
        sel_trim[0] ? {4'h0, trim_val[0]} :
        sel_trim[1] ? {4'h0, trim_val[1]} :
        sel_trim[2] ? {4'h0, trim_val[2]} :
        sel_trim[3] ? {4'h0, trim_val[3]} : 16'h0000; // [R11] [R14]

    // Address phase registers the index; data is returned one phase later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= {16'h0000, rd_mux};
        end
    end

    // Read data comes from rd_mux combinationally in the data phase
    assign hrdata = rd_pend_q ? {16'h0000, rd_mux} : rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule
`default_nettype wire

// *** hw/lat_pkg.sv ***
// Package of offsets, field layouts and reset values for the lane alarm and offset trim registers
package lat_pkg;
    // Printed offsets are not all multiples of four, so they are register indices
    localparam logic [11:0] LAT_IDX_CORE0_TRIM = 12'h330;
    localparam logic [11:0] LAT_IDX_CORE1_TRIM = 12'h332;
    localparam logic [11:0] LAT_IDX_CORE2A_TRIM = 12'h334;
    localparam logic [11:0] LAT_IDX_CORE2B_TRIM = 12'h336;
    // Own registers: lane flags, summary, mask, calibration control/status
    localparam logic [11:0] LAT_IDX_LANE_FLAGS = 12'h2c4;
    localparam logic [11:0] LAT_IDX_SUMMARY = 12'h2c0;
    localparam logic [11:0] LAT_IDX_IRQ_MASK = 12'h2c2;
    localparam logic [11:0] LAT_IDX_CAL_CTRL = 12'h340;
    // Field layout
    localparam int LAT_LANES = 8;
    localparam int LAT_TRIM_W = 12;
    localparam int LAT_REG_W = 16;
    localparam int LAT_SUMMARY_BIT = 5;
    localparam int LAT_OFFSET_CAL_ENABLE_BIT = 0;
    localparam int LAT_BACKGROUND_CAL_ENABLE_BIT = 1;
    localparam int LAT_BACKGROUND_OFFSET_CAL_ENABLE_BIT = 2;
    localparam int LAT_CAL_DONE_BIT = 3;
    localparam int LAT_CAL_BUSY_BIT = 4;
    // Reset values
    localparam logic [7:0] LAT_LANE_FLAGS_RST = 8'hff;
    localparam logic [7:0] LAT_SUMMARY_RST = 8'h20;
    localparam logic [7:0] LAT_IRQ_MASK_RST = 8'h20;
    localparam logic [11:0] LAT_TRIM_RST = 12'h000;
    localparam logic [2:0] LAT_CAL_CTRL_RST = 3'h0;
    // Bus encodings
    localparam logic [1:0] LAT_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] LAT_HSIZE_WORD = 3'h2;
endpackage

// *** hw/lat_sticky_bit.sv ***
// One sticky alarm bit: set by an event, cleared by software, set wins
`timescale 1ns/1ns
`default_nettype none
module lat_sticky_bit (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    logic flag_q;
    logic flag_d;

    // Event beats a clear in the same cycle
    assign flag_d = set_i | (flag_q & ~clr_i); // [R19] [R3]
    assign flag_o = flag_q;

    // Flag comes up set after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= 1'b1; // [R18]
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule
`default_nettype wire

// *** hw/lat_trim_reg.sv ***
// One offset trim register, preloaded from fuse storage after reset
`timescale 1ns/1ns
`default_nettype none
module lat_trim_reg #(
    parameter int WIDTH = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fuse_load_i,
    input wire logic [WIDTH-1:0] fuse_value_i,
    input wire logic wr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] trim_o
);
    logic [WIDTH-1:0] trim_q;

    assign trim_o = trim_q;

    // Fuse load replaces the nominal zero; software writes afterwards
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trim_q <= '0;
        end else if (fuse_load_i) begin
            trim_q <= fuse_value_i; // [R16]
        end else if (wr_i) begin
            trim_q <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// *** dv/lat_regs_sva.sv ***
// Checker for trim readback, trim causes, lane flag setting and interrupt cause
`timescale 1ns/1ns
`default_nettype none
module lat_regs_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [lat_pkg::LAT_LANES-1:0] lane_fifo_fault,
    input wire logic core2_sel_input_b,
    input wire logic [lat_pkg::LAT_TRIM_W-1:0] core0_trim,
    input wire logic [lat_pkg::LAT_TRIM_W-1:0] core1_trim,
    input wire logic [lat_pkg::LAT_TRIM_W-1:0] core2_trim,
    input wire logic irq
);
    import lat_pkg::*;
    logic wr_q, rd_q, ld_q, seen_q;
    logic [31:0] ad_q;
    wire logic take = hsel && hready && htrans == LAT_HTRANS_NONSEQ;
    // Data phase tracking, first-edge fuse load flag, any write seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wr_q, rd_q, seen_q} <= 3'h0;
            ld_q <= 1'b1;
            ad_q <= 32'h0;
        end else begin
            wr_q <= take && hwrite;
            rd_q <= take && !hwrite;
            ad_q <= haddr;
            ld_q <= 1'b0;
            seen_q <= seen_q || wr_q;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_rd_core0: assert property (rd_q && ad_q == 32'hcc0 |-> hrdata[11:0] == core0_trim)
        else $error("core 0 trim differs from its register");
    a_rd_core1: assert property (rd_q && ad_q == 32'hcc8 |-> hrdata[11:0] == core1_trim)
        else $error("core 1 trim differs from its register");
    a_core0_write: assert property (wr_q && ad_q == 32'hcc0 |=> core0_trim == $past(hwdata[11:0]))
        else $error("core 0 trim missed its write");
    a_core1_write: assert property (wr_q && ad_q == 32'hcc8 |=> core1_trim == $past(hwdata[11:0]))
        else $error("core 1 trim missed its write");
    a_core0_cause: assert property ($changed(core0_trim) |-> $past(wr_q) || $past(ld_q))
        else $error("core 0 trim changed without cause");
    a_core1_cause: assert property ($changed(core1_trim) |-> $past(wr_q) || $past(ld_q))
        else $error("core 1 trim changed without cause");
    a_core2_pair_a: assert property ((!core2_sel_input_b) [*4] ##0 (rd_q && ad_q == 32'hcd0)
        |-> hrdata[11:0] == core2_trim) else $error("core 2 not on pair A trim");
    a_core2_pair_b: assert property (core2_sel_input_b [*4] ##0 (rd_q && ad_q == 32'hcd8)
        |-> hrdata[11:0] == core2_trim) else $error("core 2 not on pair B trim");
    a_lane_flag_set: assert property (rd_q && ad_q == 32'hb10 |->
        (hrdata[7:0] & $past(lane_fifo_fault, 3)) == $past(lane_fifo_fault, 3))
        else $error("faulting lane flag reads clear");
    a_irq_cause: assert property (irq |-> seen_q)
        else $error("interrupt while masked from reset");
    c_trim_read: cover property (rd_q && ad_q == 32'hcc0);
    c_pair_b: cover property (core2_sel_input_b && rd_q);
    c_irq: cover property (irq);
endmodule
bind lat_regs lat_regs_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .lane_fifo_fault(lane_fifo_fault),
    .core2_sel_input_b(core2_sel_input_b), .core0_trim(core0_trim), .core1_trim(core1_trim),
    .core2_trim(core2_trim), .irq(irq));
`default_nettype wire

// *** dv/lat_regs_bench.sv ***
// Self-checking bench for the lane alarm and offset trim register bank
`timescale 1ns/1ns
`default_nettype none
module lat_regs_bench;
    import lat_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq, oe, be, bo;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0;
    logic [7:0] flt = 0, act = 8'hff, m;
    logic done = 0, busy = 0, selb = 0;
    logic [11:0] fz [4], c0, c1, c2;
    int n_fail = 0, total_checks = 0, tr [4];
    lat_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(LAT_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .lane_fifo_fault(flt), .lane_active(act),
        .foreground_cal_done(done), .cal_busy(busy), .core2_sel_input_b(selb),
        .fuse_core0_trim(fz[0]), .fuse_core1_trim(fz[1]), .fuse_core2a_trim(fz[2]),
        .fuse_core2b_trim(fz[3]), .core0_trim(c0), .core1_trim(c1), .core2_trim(c2),
        .offset_cal_enable(oe), .background_cal_enable(be), .background_offset_cal_enable(bo), .irq(irq));
    // Clock and watchdog
    initial forever #10 hclk = ~hclk;
    initial begin
        #200000;
        n_fail++;
        report_and_stop;
    end
    task automatic report_and_stop;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask
    function automatic logic [31:0] ba(input logic [11:0] i);
        return {18'h0, i, 2'b00};
    endfunction
    // One AHB-Lite single word transfer, waiting on hready in both phases
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n = 0;
        hsel <= 1;
        htrans <= LAT_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
        r = hrdata;
        chk(hresp, 0);
        if (n >= 50) chk(0, 1);
    endtask
    task automatic wr(input logic [11:0] i, input logic [31:0] d);
        bus(1, ba(i), d);
    endtask
    task automatic rd(input logic [11:0] i, input logic [31:0] e);
        bus(0, ba(i), 0);
        chk(r, e);
    endtask
    task automatic ci(input logic e);
        repeat (2) @(posedge hclk);
        chk(irq, e);
    endtask
    task automatic do_reset;
        hresetn <= 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        repeat (2) @(posedge hclk);
    endtask
    // Main sequence
    initial begin
        void'($urandom(37));
        foreach (fz[k]) fz[k] <= 12'($urandom);
        do_reset;
        for (int k = 0; k < 4; k++) rd(LAT_IDX_CORE0_TRIM + 12'(2 * k), fz[k]);
        rd(LAT_IDX_LANE_FLAGS, 32'hff);
        rd(LAT_IDX_SUMMARY, 32'h20);
        rd(LAT_IDX_IRQ_MASK, 32'h20);
        for (int k = 0; k < 4; k++) begin
            tr[k] = (k == 0) ? 12'hfff : 12'($urandom);
            wr(LAT_IDX_CORE0_TRIM + 12'(2 * k), tr[k]);
        end
        chk(c0, tr[0]);
        chk(c1, tr[1]);
        chk(c2, tr[2]);
        for (int k = 0; k < 4; k++) rd(LAT_IDX_CORE0_TRIM + 12'(2 * k), tr[k]);
        selb <= 1;
        repeat (4) @(posedge hclk);
        chk(c2, tr[3]);
        rd(LAT_IDX_CORE2B_TRIM, tr[3]);
        wr(12'hfc0, 32'hffff);
        rd(12'hfc0, 0);
        wr(LAT_IDX_SUMMARY, 32'h20);
        rd(LAT_IDX_LANE_FLAGS, 0);
        rd(LAT_IDX_SUMMARY, 0);
        m = 8'($urandom_range(255, 1));
        act <= 8'($urandom);
        flt <= m;
        repeat (2) @(posedge hclk);
        flt <= 0;
        repeat (4) @(posedge hclk);
        rd(LAT_IDX_LANE_FLAGS, m);
        rd(LAT_IDX_SUMMARY, (|(m & act)) ? 32'h20 : 0);
        wr(LAT_IDX_LANE_FLAGS, m & 8'h0f);
        rd(LAT_IDX_LANE_FLAGS, m & 8'hf0);
        flt <= 8'h81;
        repeat (4) @(posedge hclk);
        wr(LAT_IDX_LANE_FLAGS, 32'hff);
        rd(LAT_IDX_LANE_FLAGS, 32'h81);
        wr(LAT_IDX_SUMMARY, 32'h20);
        rd(LAT_IDX_LANE_FLAGS, 32'h81);
        flt <= 0;
        act <= 8'hff;
        repeat (4) @(posedge hclk);
        wr(LAT_IDX_LANE_FLAGS, 32'hff);
        wr(LAT_IDX_SUMMARY, 32'h20);
        rd(LAT_IDX_LANE_FLAGS, 0);
        wr(LAT_IDX_IRQ_MASK, 0);
        ci(0);
        flt <= 8'h10;
        repeat (2) @(posedge hclk);
        flt <= 0;
        ci(1);
        wr(LAT_IDX_IRQ_MASK, 32'h20);
        ci(0);
        wr(LAT_IDX_IRQ_MASK, 0);
        ci(1);
        wr(LAT_IDX_SUMMARY, 32'h20);
        ci(0);
        for (int k = 0; k < 8; k++) begin
            {busy, done} <= 2'(k);
            wr(LAT_IDX_CAL_CTRL, 32'(k));
            // Enables take the new value at the write's closing edge; look one edge later
            @(posedge hclk);
            chk({bo, be, oe}, 32'(k));
            rd(LAT_IDX_CAL_CTRL, 32'(((k & 3) << 3) | k));
        end
        do_reset;
        rd(LAT_IDX_LANE_FLAGS, 32'hff);
        rd(LAT_IDX_CORE0_TRIM, fz[0]);
        report_and_stop;
    end
endmodule
`default_nettype wire
